// *** core/tmc_timer_ctrl.sv ***
// Purpose: AHB-Lite front end for timer command decode and count loading
// Assumes: single word transfers, one slave on the bus, synchronous inputs
// Notes: every transfer takes one wait state; the response is always OKAY
// Notes: count reads give stored bytes, no live count
// Notes: status word is read only; command reads zero
// Notes: latch and read-back leave as request pulses
// Notes: only word-sized transfers hit a register
//
// Design decision made here: the AHB-Lite register port.

`timescale 1ns/1ps
`default_nettype none
`include "tmc_cfg.svh"

module tmc_timer_ctrl
	import tmc_pkg::*;
#(
	parameter int ADDR_W = 32                        // bus address width
)
(
	input  wire logic              core_clk,        // block clock, 40 MHz
	input  wire logic              reset_n,         // async reset, active low
	input  wire logic              hsel,            // slave select
	input  wire logic [ADDR_W-1:0] haddr,           // byte address
	input  wire logic [1:0]        htrans,          // transfer type
	input  wire logic              hwrite,          // write when high
	input  wire logic [2:0]        hsize,           // transfer size
	input  wire logic              hready,          // bus ready
	input  wire logic [31:0]       hwdata,          // write data
	output logic [31:0]            hrdata,          // read data
	output logic                   hreadyout,       // slave ready
	output logic                   hresp,           // always OKAY
	output logic [2:0]             counter_output,  // per counter output level
	output logic [2:0][15:0]       count_value,     // loaded counts
	output logic [2:0]             count_loaded,    // count complete pulses
	output tmc_pkg::tmc_cfg_t [2:0] counter_cfg,    // per counter configuration
	output logic [2:0]             latch_req,       // counter-latch pulses
	output logic                   readback_req,    // read-back pulse
	output logic [7:0]             readback_byte    // read-back command byte
);
	import tmc_pkg::*;

	// status lanes fit at most four counters
	localparam int NCNT = 3;                        // number of counters

	// one hit bit per port spares a second
	// address compare in the data phase;
	// bits 0-2 match the counter index
	// hit vector bit positions
	localparam int HIT_CMD  = 3;                    // command port
	localparam int HIT_STAT = 4;                    // status word

	// one struct keeps reset and next state
	// from drifting apart
	tmc_bus_state_t b_r;                            // registered bus state
	tmc_bus_state_t b_nxt;                          // next bus state

	// decode results of the current phase
	tmc_cmd_t        cmd;                           // decoded command byte
	logic [4:0]      addr_hit;                      // address phase decode
	logic            take;                          // address phase accepted
	logic            do_wr;                         // data phase write
	logic            do_rd;                         // data phase read

	// per counter strobes, one cycle each
	logic [NCNT-1:0] cfg_we;                        // control word per counter
	logic [NCNT-1:0] data_we;                       // count write per counter
	logic [NCNT-1:0] rd_re;                         // count read per counter
	tmc_cfg_t [NCNT-1:0] cfg_q;                     // loader configurations
	logic [NCNT-1:0][15:0] count_q;                 // loader counts
	logic [NCNT-1:0] load_q;                        // loader load pulses
	logic [NCNT-1:0] complete_q;                    // loader complete flags
	logic [NCNT-1:0] out_q;                         // loader output levels
	logic [NCNT-1:0][7:0] rd_byte;                  // loader read bytes
	// status image, one byte per counter
	logic [31:0]     stat_word;                     // status word image

	// the wait state gives hwdata a whole
	// cycle to settle before its decode
	// steers the loaders, at one cycle a
	// transfer; hreadyout low meanwhile
	// keeps a second address phase out
	// a transfer starts on nonseq or seq while the bus is ready
	assign take  = hsel && htrans[1] && hready && (b_r.st == TMC_ST_IDLE);
	assign do_wr = (b_r.st == TMC_ST_ACCESS) && b_r.write;
	assign do_rd = (b_r.st == TMC_ST_ACCESS) && !b_r.write;

	// address decode; only whole aligned words hit a register
	// narrow or misaligned accesses answer
	// OKAY and touch nothing, so a byte
	// probe cannot half-program a counter
	// addresses are distinct; order is moot
	always_comb
	begin
		addr_hit = 5'h00;
		if (hsize != 3'h2 || haddr[1:0] != 2'h0)
		begin
			addr_hit = 5'h00;
		end
		else if (haddr == ADDR_W'({`TMC_IDX_CNT0, 2'h0}))
		begin
			addr_hit = 5'h01;
		end
		else if (haddr == ADDR_W'({`TMC_IDX_CNT1, 2'h0}))
		begin
			addr_hit = 5'h02;
		end
		else if (haddr == ADDR_W'({`TMC_IDX_CNT2, 2'h0}))
		begin
			addr_hit = 5'h04;
		end
		else if (haddr == ADDR_W'({`TMC_IDX_CMD, 2'h0}))
		begin
			addr_hit = 5'h08;
		end
		else if (haddr == ADDR_W'({`TMC_IDX_STAT, 2'h0}))
		begin
			addr_hit = 5'h10;
		end
		else
		begin
			// unmapped: reads zero, writes dropped
			addr_hit = 5'h00;
		end
	end

	// command byte sorter; its result only
	// matters in a command write's data phase
	tmc_cmd_decode u_decode (
		.cmd_byte (hwdata[7:0]),
		.cmd      (cmd)
	);

	// per counter strobes and loaders
	// all loaders see the same fields and
	// byte; only their own strobes let them
	// take it, so the rest keep their setup
	// a count read steps only its own pointer
	// the loop index is the counter index
	genvar gi;
	generate
		for (gi = 0; gi < NCNT; gi++)
		begin : g_cnt
			// only the addressed counter sees a control word
			assign cfg_we[gi]  = do_wr && b_r.hit[HIT_CMD] && (cmd.kind == TMC_KIND_CTRL)
			                     && (cmd.sel == 2'(gi));
			assign data_we[gi] = do_wr && b_r.hit[gi];
			assign rd_re[gi]   = do_rd && b_r.hit[gi];

			tmc_count_loader u_loader (
				.core_clk   (core_clk),
				.reset_n    (reset_n),
				.cfg_we     (cfg_we[gi]),
				.cfg_in     (cmd.cfg),
				.data_we    (data_we[gi]),
				.data_in    (hwdata[7:0]),
				.rd_re      (rd_re[gi]),
				.cfg_q      (cfg_q[gi]),
				.count_q    (count_q[gi]),
				.load_q     (load_q[gi]),
				.complete_q (complete_q[gi]),
				.out_q      (out_q[gi]),
				.rd_byte    (rd_byte[gi])
			);

			// status lane: {out, complete, order, mode, bcd}
			// eight bits a counter, counter 0 lowest
			assign stat_word[gi*`TMC_STAT_STRIDE +: `TMC_STAT_STRIDE] =
				{out_q[gi], complete_q[gi], cfg_q[gi]};
		end
	endgenerate

	// upper status byte reads as zero
	// the status image has no read side
	// effect, unlike a low/high count read
	assign stat_word[31:NCNT*`TMC_STAT_STRIDE] = '0;

	// bus phase and side requests
	// idle waits for a transfer; access is
	// the single wait cycle where the write
	// lands or the read byte is picked
	// request pulses clear by default so
	// each lasts exactly one cycle
	always_comb
	begin
		b_nxt       = b_r;
		b_nxt.latch = 3'h0;
		b_nxt.rb    = 1'b0;
		case (b_r.st)
			TMC_ST_IDLE:
			begin
				if (take)
				begin
					// capture direction and decode now;
					// the address is gone by the data phase
					// hold off the master one cycle so data is ready
					b_nxt.st    = TMC_ST_ACCESS;
					b_nxt.write = hwrite;
					b_nxt.hit   = addr_hit;
					b_nxt.ready = 1'b0;
				end
			end
			TMC_ST_ACCESS:
			begin
				b_nxt.st    = TMC_ST_IDLE;
				b_nxt.ready = 1'b1;
				// a write leaves zero read data
				b_nxt.rdata = 32'h0000_0000;
				if (b_r.write && b_r.hit[HIT_CMD])
				begin
					// latch and read-back go out as requests only
					// a control word needs nothing here;
					// its loader took it through cfg_we
					if (cmd.kind == TMC_KIND_LATCH)
					begin
						b_nxt.latch = 3'(1 << cmd.sel);
					end
					else if (cmd.kind == TMC_KIND_READBACK)
					begin
						b_nxt.rb      = 1'b1;
						b_nxt.rb_byte = hwdata[7:0];
					end
				end
				else if (!b_r.write)
				begin
					// count reads give the byte the pointer names
					if (b_r.hit[0])
					begin
						b_nxt.rdata = {24'h00_0000, rd_byte[0]};
					end
					else if (b_r.hit[1])
					begin
						b_nxt.rdata = {24'h00_0000, rd_byte[1]};
					end
					else if (b_r.hit[2])
					begin
						b_nxt.rdata = {24'h00_0000, rd_byte[2]};
					end
					else if (b_r.hit[HIT_STAT])
					begin
						b_nxt.rdata = stat_word;
					end
					else
					begin
						// command port is write only
						b_nxt.rdata = 32'h0000_0000;
					end
				end
			end
			default:
			begin
				// unused code: release the bus
				b_nxt.st    = TMC_ST_IDLE;
				b_nxt.ready = 1'b1;
			end
		endcase
	end

	// bus state register
	// reset leaves the slave idle and ready,
	// so the first edge after release may take
	// rb_byte holds until the next read-back
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			b_r.st      <= TMC_ST_IDLE;
			b_r.write   <= 1'b0;
			b_r.hit     <= 5'h00;
			b_r.ready   <= 1'b1;
			b_r.rdata   <= 32'h0000_0000;
			b_r.latch   <= 3'h0;
			b_r.rb      <= 1'b0;
			b_r.rb_byte <= `TMC_CMD_RST;
		end
		else
		begin
			// the whole struct moves at once
			b_r <= b_nxt;
		end
	end

	// outputs straight from flops here or in the loaders
	// nothing sits between a flop and a pin,
	// so both sides see clean levels
	// hresp stays OKAY: no access is refused
	assign hrdata         = b_r.rdata;
	assign hreadyout      = b_r.ready;
	assign hresp          = 1'b0;
	assign counter_output = out_q;
	assign count_value    = count_q;
	assign count_loaded   = load_q;
	assign counter_cfg    = cfg_q;
	assign latch_req      = b_r.latch;
	assign readback_req   = b_r.rb;
	assign readback_byte  = b_r.rb_byte;

	// limitation: only requests leave here;
	// latching a count and building read-back
	// status belong to the counting logic

endmodule

`default_nettype wire

// *** core/tmc_cfg.svh ***
// Purpose: constants for the timer command decode and count loading block
// Assumes: included by bare name; every file that needs a constant includes it
// Notes: register offsets are word indices; the bus byte address is four times the index
//
// How it works
// - command byte format chosen by its bits
// - control word sets output initial level
// - bits 7-6 select counter 0, 1, 2
// - selector 11 means read-back command
// - bits 5-4 give byte access order
// - order 00 means counter-latch command
// - bits 3-1 give mode, 11x folds down
// - bit 0 picks binary or bcd count
// - count writes leave mode untouched
// - data port carries one count byte

`ifndef TMC_CFG_SVH
`define TMC_CFG_SVH

// register word indices (byte address = index * 4)
`define TMC_IDX_CNT0      16'hF040
`define TMC_IDX_CNT1      16'hF041
`define TMC_IDX_CNT2      16'hF042
`define TMC_IDX_CMD       16'hF043
`define TMC_IDX_STAT      16'hF044

// command byte field positions
`define TMC_SEL_POS       6
`define TMC_ORD_POS       4
`define TMC_MODE_POS      1
`define TMC_FMT_POS       0

// field codes
`define TMC_SEL_READBACK  2'h3
`define TMC_ORD_LATCH     2'h0
`define TMC_ORD_LSB       2'h1
`define TMC_ORD_MSB       2'h2
`define TMC_ORD_LH        2'h3
`define TMC_MODE_LOW_MASK 3'h3

// reset values
`define TMC_CMD_RST       8'h00
`define TMC_CFG_RST       6'h10
`define TMC_COUNT_RST     16'h0000
`define TMC_OUT_RST       1'b0
`define TMC_STAT_STRIDE   8

`endif

// *** core/tmc_pkg.sv ***
// Purpose: shared types for the timer command decode and count loading block
// Assumes: tmc_cfg.svh holds every numeric constant except the enum codes below
// Notes: enum members carry literal codes; no header macro is used here

`include "tmc_cfg.svh"

package tmc_pkg;

	// what a command byte turned out to be
	typedef enum logic [1:0] {
		TMC_KIND_CTRL     = 2'h0,
		TMC_KIND_LATCH    = 2'h1,
		TMC_KIND_READBACK = 2'h3
	} tmc_kind_t;

	// bus slave phase, gray along idle -> access -> idle
	typedef enum logic [1:0] {
		TMC_ST_IDLE   = 2'h0,
		TMC_ST_ACCESS = 2'h1
	} tmc_bus_st_t;

	// per counter configuration
	typedef struct packed {
		logic [1:0] order;     // byte access order
		logic [2:0] mode;      // normalised operating mode 0..5
		logic       bcd;       // count format select
	} tmc_cfg_t;

	// decoded command byte
	typedef struct packed {
		tmc_kind_t  kind;      // control word, latch or read-back
		logic [1:0] sel;       // counter selector
		tmc_cfg_t   cfg;       // fields for a control word
	} tmc_cmd_t;

	// count loader state
	typedef struct packed {
		tmc_cfg_t    cfg;      // programmed configuration
		logic [15:0] count;    // count value
		logic        wr_hi;    // next write goes to high byte
		logic        rd_hi;    // next read gives high byte
		logic        complete; // full count present
		logic        load;     // one cycle count loaded pulse
		logic        out;      // counter output level
	} tmc_ld_state_t;

	// bus slave state
	typedef struct packed {
		tmc_bus_st_t st;       // phase
		logic        write;    // captured hwrite
		logic [4:0]  hit;      // {stat, cmd, cnt2, cnt1, cnt0}
		logic        ready;    // hreadyout
		logic [31:0] rdata;    // hrdata
		logic [2:0]  latch;    // latch request pulses
		logic        rb;       // read-back request pulse
		logic [7:0]  rb_byte;  // read-back command byte
	} tmc_bus_state_t;

endpackage

// *** core/tmc_cmd_decode.sv ***
// Purpose: sort a command byte into control word, latch or read-back
// Assumes: pure combinational, used on the bus write data
// Notes: read-back takes priority over the latch test

`timescale 1ns/1ps
`default_nettype none
`include "tmc_cfg.svh"

module tmc_cmd_decode
	import tmc_pkg::*;
(
	input  wire logic [7:0]      cmd_byte,  // byte written to the command port
	output var  tmc_pkg::tmc_cmd_t cmd      // decoded command
);
	import tmc_pkg::*;

	logic [1:0] sel_f;  // selector field
	logic [1:0] ord_f;  // order field
	logic [2:0] mode_f; // raw mode field

	// field extraction
	assign sel_f  = cmd_byte[`TMC_SEL_POS+1:`TMC_SEL_POS];
	assign ord_f  = cmd_byte[`TMC_ORD_POS+1:`TMC_ORD_POS];
	assign mode_f = cmd_byte[`TMC_MODE_POS+2:`TMC_MODE_POS];

	// format choice by bit values alone
	always_comb
	begin
		cmd.sel       = sel_f;
		cmd.cfg.order = ord_f;
		cmd.cfg.bcd   = cmd_byte[`TMC_FMT_POS];
		// top bit is a don't care when the low two are x1x
		if (mode_f[1])
		begin
			cmd.cfg.mode = mode_f & `TMC_MODE_LOW_MASK;
		end
		else
		begin
			cmd.cfg.mode = mode_f;
		end
		if (sel_f == `TMC_SEL_READBACK)
		begin
			cmd.kind = TMC_KIND_READBACK;
		end
		else if (ord_f == `TMC_ORD_LATCH)
		begin
			cmd.kind = TMC_KIND_LATCH;
		end
		else
		begin
			cmd.kind = TMC_KIND_CTRL;
		end
	end

endmodule

`default_nettype wire

// *** core/tmc_count_loader.sv ***
// Purpose: hold one counter's configuration and assemble its count bytes
// Assumes: at most one of cfg_we, data_we, rd_re per cycle
// Notes: rd_byte is combinational; the caller registers it

`timescale 1ns/1ps
`default_nettype none
`include "tmc_cfg.svh"

module tmc_count_loader
	import tmc_pkg::*;
(
	input  wire logic             core_clk,  // block clock
	input  wire logic             reset_n,   // async reset, active low
	input  wire logic             cfg_we,    // control word for this counter
	input  wire tmc_pkg::tmc_cfg_t cfg_in,   // new configuration
	input  wire logic             data_we,   // count port write
	input  wire logic [7:0]       data_in,   // count value byte
	input  wire logic             rd_re,     // count port read
	output var  tmc_pkg::tmc_cfg_t cfg_q,    // current configuration
	output logic [15:0]           count_q,   // count value
	output logic                  load_q,    // count complete pulse
	output logic                  complete_q,// full count present
	output logic                  out_q,     // counter output level
	output logic [7:0]            rd_byte    // byte a read would return
);
	import tmc_pkg::*;

	tmc_ld_state_t s_r;   // registered state
	tmc_ld_state_t s_nxt; // next state

	// next state
	always_comb
	begin
		s_nxt      = s_r;
		s_nxt.load = 1'b0;
		if (cfg_we)
		begin
			// new programming restarts both byte pointers
			s_nxt.cfg      = cfg_in;
			s_nxt.wr_hi    = 1'b0;
			s_nxt.rd_hi    = 1'b0;
			s_nxt.complete = 1'b0;
			s_nxt.out      = (cfg_in.mode != 3'h0);
		end
		else if (data_we)
		begin
			// cfg is left alone on every count write
			case (s_r.cfg.order)
				`TMC_ORD_LSB:
				begin
					s_nxt.count    = {8'h00, data_in};
					s_nxt.complete = 1'b1;
					s_nxt.load     = 1'b1;
				end
				`TMC_ORD_MSB:
				begin
					s_nxt.count    = {data_in, 8'h00};
					s_nxt.complete = 1'b1;
					s_nxt.load     = 1'b1;
				end
				default:
				begin
					if (s_r.wr_hi)
					begin
						s_nxt.count[15:8] = data_in;
						s_nxt.wr_hi       = 1'b0;
						s_nxt.complete    = 1'b1;
						s_nxt.load        = 1'b1;
					end
					else
					begin
						s_nxt.count[7:0] = data_in;
						s_nxt.wr_hi      = 1'b1;
						s_nxt.complete   = 1'b0;
					end
				end
			endcase
		end
		else if (rd_re && s_r.cfg.order == `TMC_ORD_LH)
		begin
			s_nxt.rd_hi = ~s_r.rd_hi;
		end
	end

	// read byte follows the same order as writes
	always_comb
	begin
		if (s_r.cfg.order == `TMC_ORD_MSB || (s_r.cfg.order == `TMC_ORD_LH && s_r.rd_hi))
		begin
			rd_byte = s_r.count[15:8];
		end
		else
		begin
			rd_byte = s_r.count[7:0];
		end
	end

	// state register
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			s_r.cfg      <= `TMC_CFG_RST;
			s_r.count    <= `TMC_COUNT_RST;
			s_r.wr_hi    <= 1'b0;
			s_r.rd_hi    <= 1'b0;
			s_r.complete <= 1'b0;
			s_r.load     <= 1'b0;
			s_r.out      <= `TMC_OUT_RST;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	assign cfg_q      = s_r.cfg;
	assign count_q    = s_r.count;
	assign load_q     = s_r.load;
	assign complete_q = s_r.complete;
	assign out_q      = s_r.out;

endmodule

`default_nettype wire

// *** verification/tmc_timer_ctrl_sva.sv ***
// Purpose: port checker for the timer command decode and count loading block
// Assumes: one clock domain, single word transfers of size 2
// Notes: bound to tmc_timer_ctrl after the module
`timescale 1ns/1ps
`default_nettype none
`include "tmc_cfg.svh"

module tmc_timer_ctrl_sva
	import tmc_pkg::*;
#(
	parameter int ADDR_W = 32 // bus address width
)
(
	input wire logic              core_clk,       // block clock
	input wire logic              reset_n,        // async reset, active low
	input wire logic              hsel,           // slave select
	input wire logic [ADDR_W-1:0] haddr,          // byte address
	input wire logic [1:0]        htrans,         // transfer type
	input wire logic              hwrite,         // write when high
	input wire logic [2:0]        hsize,          // transfer size
	input wire logic              hready,         // bus ready
	input wire logic [31:0]       hwdata,         // write data
	input wire logic [31:0]       hrdata,         // read data
	input wire logic              hreadyout,      // slave ready
	input wire logic              hresp,          // response
	input wire logic [2:0]        counter_output, // output levels
	input wire logic [2:0][15:0]  count_value,    // loaded counts
	input wire logic [2:0]        count_loaded,   // count complete pulses
	input wire tmc_pkg::tmc_cfg_t [2:0] counter_cfg, // per counter configuration
	input wire logic [2:0]        latch_req,      // latch pulses
	input wire logic              readback_req,   // read-back pulse
	input wire logic [7:0]        readback_byte   // read-back byte
);
	import tmc_pkg::*;
	logic       taken;    // transfer accepted at this edge
	logic       cmd_ph_r; // command write in its wait cycle
	logic [2:0] cnt_ph_r; // count port writes in their wait cycle
	logic       ctrl_r;   // control word just performed
	logic [1:0] sel_r;    // its counter selector
	tmc_cfg_t   exp_r;    // configuration it should leave

	assign taken = hsel && htrans[1] && hready && hreadyout;

	// track write phases; hwdata is only valid in the wait cycle
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			cmd_ph_r <= 1'b0;
			cnt_ph_r <= 3'h0;
			ctrl_r   <= 1'b0;
			sel_r    <= 2'h0;
			exp_r    <= '0;
		end
		else
		begin
			cmd_ph_r <= taken && hwrite && hsize == 3'h2 && haddr == {`TMC_IDX_CMD, 2'b00};
			for (int i = 0; i < 3; i++)
				cnt_ph_r[i] <= taken && hwrite && hsize == 3'h2
					&& haddr == ({`TMC_IDX_CNT0, 2'b00} + 18'(4 * i));
			ctrl_r   <= cmd_ph_r && hwdata[7:6] != 2'h3 && hwdata[5:4] != 2'h0;
			sel_r    <= hwdata[7:6];
			// modes 11x fold down to 2 and 3
			exp_r    <= '{order: hwdata[5:4], bcd: hwdata[0],
				mode: hwdata[2] ? {1'b0, hwdata[2:1]} : hwdata[3:1]};
		end
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);

	a_one_wait_state: assert property (taken |=> !hreadyout ##1 hreadyout)
		else $error("transfer did not take exactly one wait state");
	a_readback_decode: assert property (cmd_ph_r && hwdata[7:6] == 2'h3
		|=> readback_req && readback_byte == $past(hwdata[7:0]) && latch_req == 3'h0)
		else $error("read-back command not decoded");
	a_latch_decode: assert property (cmd_ph_r && hwdata[7:6] != 2'h3 && hwdata[5:4] == 2'h0
		|=> latch_req == (3'h1 << $past(hwdata[7:6])) && !readback_req && $stable(counter_cfg))
		else $error("counter-latch command not decoded");
	a_cfg_selected: assert property (ctrl_r |-> counter_cfg[sel_r] == exp_r)
		else $error("control word fields not applied");
	a_others_kept: assert property (ctrl_r |-> (sel_r == 2'h0 || $stable(counter_cfg[0]))
		&& (sel_r == 2'h1 || $stable(counter_cfg[1])) && (sel_r == 2'h2 || $stable(counter_cfg[2])))
		else $error("control word touched another counter");
	a_out_level: assert property (ctrl_r |-> counter_output[sel_r] == (exp_r.mode != 3'h0))
		else $error("output initial level wrong for mode");
	a_count_keeps_cfg: assert property (|cnt_ph_r |=> $stable(counter_cfg))
		else $error("count write changed configuration");
	a_load_source: assert property (count_loaded != 3'h0 |-> $past(cnt_ph_r) == count_loaded)
		else $error("count complete without matching write");

	c_readback: cover property (readback_req);
	c_latch: cover property (|latch_req);
	c_loaded: cover property (|count_loaded);
endmodule

bind tmc_timer_ctrl tmc_timer_ctrl_sva #(.ADDR_W(ADDR_W)) u_sva (
	.core_clk(core_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .counter_output(counter_output),
	.count_value(count_value), .count_loaded(count_loaded), .counter_cfg(counter_cfg),
	.latch_req(latch_req), .readback_req(readback_req), .readback_byte(readback_byte));
`default_nettype wire

// *** verification/test_timer_control_word_and_count_load.sv ***
// Purpose: self-checking bench for the timer command decode and count loading block
// Assumes: bench is the only bus master; hready follows hreadyout
// Notes: each task drives right after a rising edge and returns at one
`timescale 1ns/1ps
`default_nettype none
`include "tmc_cfg.svh"

module test_timer_control_word_and_count_load;
	import tmc_pkg::*;
	localparam logic [31:0] A_CNT0 = {14'h0, `TMC_IDX_CNT0, 2'b00}; // counter 0 port
	localparam logic [31:0] A_CMD  = {14'h0, `TMC_IDX_CMD, 2'b00};  // command port
	localparam logic [31:0] A_BAD  = 32'h0003_C200;                 // unmapped

	logic             core_clk, reset_n, hsel, hwrite;  // clock, reset, bus control
	logic [31:0]      haddr, hwdata, hrdata, rd;        // bus address and data
	logic [1:0]       htrans;                           // transfer type
	logic [2:0]       hsize;                            // always a word
	logic             hreadyout, hresp, readback_req;   // slave answers
	logic [2:0]       counter_output, count_loaded, latch_req;
	logic [2:0][15:0] count_value;                      // loaded counts
	tmc_cfg_t [2:0]   counter_cfg;                      // configurations
	logic [7:0]       readback_byte;                    // read-back byte
	logic [2:0]       seen_load, seen_latch;            // pulses at completion
	logic             seen_rb;                          // read-back pulse seen
	int               bad_count, samples_checked;       // verdict counters

	tmc_timer_ctrl u_dut (
		.core_clk(core_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .counter_output(counter_output),
		.count_value(count_value), .count_loaded(count_loaded), .counter_cfg(counter_cfg),
		.latch_req(latch_req), .readback_req(readback_req), .readback_byte(readback_byte));

	always #12.5 core_clk = ~core_clk;

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// one single transfer; pulses are sampled at the completion edge
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd);
		int n;
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= a;
		hwrite <= w;
		n = 0;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (hreadyout !== 1'b1 && n < 20);
		if (hreadyout !== 1'b1) bad_count++;
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		n = 0;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (hreadyout !== 1'b1 && n < 20);
		if (hreadyout !== 1'b1) bad_count++;
		rd = hrdata;
		seen_load = count_loaded;
		seen_latch = latch_req;
		seen_rb = readback_req;
	endtask

	// every mode code, both formats, all orders, rotating counters
	task automatic t_modes();
		tmc_cfg_t exp [3];
		logic [2:0] m;
		for (int j = 0; j < 3; j++)
			exp[j] = counter_cfg[j];
		for (int i = 0; i < 8; i++)
		begin
			m = 3'(i);
			xfer(1'b1, A_CMD, {24'h0, 2'(i % 3), 2'(i % 3 + 1), m, m[0]});
			exp[i % 3] = '{order: 2'(i % 3 + 1), bcd: m[0], mode: m[1] ? {1'b0, m[1:0]} : m};
			for (int j = 0; j < 3; j++)
				chk(counter_cfg[j], exp[j]);
			chk(counter_output[i % 3], m != 3'h0);
			chk({seen_latch, seen_rb}, 4'h0);
		end
	endtask

	// low then high on counter 1, with a restart mid count
	task automatic t_pair();
		xfer(1'b1, A_CMD, 32'h74);
		xfer(1'b1, A_CNT0 + 4, 32'hFFFF_FF34);
		chk(seen_load, 3'h0);
		xfer(1'b1, A_CNT0 + 4, 32'h12);
		chk({seen_load, count_value[1]}, {3'h2, 16'h1234});
		xfer(1'b1, A_CNT0 + 4, 32'hAA);
		xfer(1'b1, A_CMD, 32'h74);
		xfer(1'b1, A_CNT0 + 4, 32'h56);
		chk(seen_load, 3'h0);
		xfer(1'b1, A_CNT0 + 4, 32'h78);
		chk({seen_load, count_value[1]}, {3'h2, 16'h7856});
		chk(counter_cfg[1], 6'h34);
		xfer(1'b0, A_CNT0 + 4, 32'h0);
		chk(rd, 32'h56);
		xfer(1'b0, A_CNT0 + 4, 32'h0);
		chk(rd, 32'h78);
	endtask

	// single byte orders on counter 2, latch and read-back commands
	task automatic t_cmds();
		xfer(1'b1, A_CMD, 32'h90);
		xfer(1'b1, A_CNT0 + 8, 32'h9A);
		chk({seen_load, count_value[2]}, {3'h4, 16'h009A});
		xfer(1'b1, A_CMD, 32'hA0);
		xfer(1'b1, A_CNT0 + 8, 32'hBC);
		chk({seen_load, count_value[2]}, {3'h4, 16'hBC00});
		for (int s = 0; s < 3; s++)
		begin
			xfer(1'b1, A_CMD, {24'h0, 2'(s), 6'h0});
			chk({seen_latch, seen_rb, counter_cfg[1]}, {3'h1 << s, 1'b0, 6'h34});
		end
		xfer(1'b1, A_CMD, 32'hC5);
		chk({seen_rb, seen_latch, readback_byte}, {1'b1, 3'h0, 8'hC5});
		xfer(1'b1, A_BAD, 32'hFF);
		xfer(1'b0, A_BAD, 32'h0);
		chk(rd, 32'h0);
		chk(counter_cfg[1], 6'h34);
		xfer(1'b0, A_CMD, 32'h0);
		chk(rd, 32'h0);
		xfer(1'b0, A_CNT0 + 16, 32'h0);
		chk(rd, 32'h0060_F494);
	endtask

	initial
	begin
		core_clk = 1'b0;
		reset_n = 1'b0;
		{hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsize = 3'h2;
		bad_count = 0;
		samples_checked = 0;
		repeat (2) @(posedge core_clk);
		reset_n <= 1'b1;
		@(posedge core_clk);
		chk({counter_cfg, counter_output}, {{3{6'h10}}, 3'h0});
		chk({count_value[2], count_value[1]}, 32'h0);
		chk({count_value[0], readback_byte, hresp, hreadyout}, {16'h0, 8'h0, 1'b0, 1'b1});
		t_modes();
		t_pair();
		t_cmds();
		summarize();
	end

	// hang guard, far beyond the roughly 90 cycles the tests need
	initial
	begin
		#200000;
		bad_count++;
		summarize();
	end
endmodule
`default_nettype wire
